// File: common/llirq_pkg.sv
// Package with register map, field layout and carrier types for the loopback/LAPD irq block.
package llirq_pkg;

  // Register indices; each register is one word, so its byte address is four times its index.
  localparam logic [7:0] IDX_OVERSIZE_STAT = 8'h18;
  localparam logic [7:0] IDX_OVERSIZE_EN   = 8'h19;
  localparam logic [7:0] IDX_LOOP_STAT     = 8'h1A;
  localparam logic [7:0] IDX_LOOP_EN       = 8'h1B;
  localparam logic [7:0] OFS_OVERSIZE_EN   = {IDX_OVERSIZE_EN[5:0], 2'h0};
  localparam logic [7:0] OFS_OVERSIZE_STAT = {IDX_OVERSIZE_STAT[5:0], 2'h0};
  localparam logic [7:0] OFS_LOOP_STAT     = {IDX_LOOP_STAT[5:0], 2'h0};
  localparam logic [7:0] OFS_LOOP_EN       = {IDX_LOOP_EN[5:0], 2'h0};

  // Field positions.
  localparam int BIT_OVERSIZE_EN    = 0;
  localparam int BIT_OVERSIZE_FLAG  = 0;
  localparam int BIT_ACT_LIVE       = 3;
  localparam int BIT_DEACT_LIVE     = 2;
  localparam int BIT_ACT_CHANGE     = 1;
  localparam int BIT_DEACT_CHANGE   = 0;
  localparam int BIT_ACT_EN         = 1;
  localparam int BIT_DEACT_EN       = 0;

  // Reset values.
  localparam logic [7:0] RST_REG8 = 8'h00;

  // Message length above which the oversize event fires.
  localparam int OVERSIZE_LIMIT_BYTES = 276;

  // Live detector inputs, traveling together.
  typedef struct packed {
    logic act_det;
    logic deact_det;
    logic act_det_en;
    logic deact_det_en;
  } llirq_det_t;

  // APB request carrier.
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } llirq_apb_req_t;

endpackage

// File: hw/llirq_edge_flag.sv
// Change detector with a sticky flag cleared by read; set wins over clear.
`timescale 1ns/100ps
module llirq_edge_flag (
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  input  wire logic i_level,
  input  wire logic i_clr,
  output logic      o_level,
  output logic      o_flag
);

  logic level_q;
  logic flag_q;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      level_q <= 1'b0;
    end else begin
      level_q <= i_level;
    end
  end

  // Either direction of change sets the flag; a clear in the same cycle loses.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      flag_q <= 1'b0;
    end else if (i_level != level_q) begin
      flag_q <= 1'b1;
    end else if (i_clr) begin
      flag_q <= 1'b0;
    end
  end

  assign o_level = level_q;
  assign o_flag  = flag_q;

endmodule // llirq_edge_flag

// File: hw/llirq_top.sv
// APB register block with oversize-LAPD and loopback-code change status and interrupt request.
`timescale 1ns/100ps
module llirq_top (
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_rst,
  input  wire logic                     i_psel,
  input  wire logic                     i_penable,
  input  wire logic                     i_pwrite,
  input  wire logic [7:0]               i_paddr,
  input  wire logic [31:0]              i_pwdata,
  input  wire logic [3:0]               i_pstrb,
  output logic      [31:0]              o_prdata,
  output logic                          o_pready,
  output logic                          o_pslverr,
  input  wire llirq_pkg::llirq_det_t    i_det,
  input  wire logic                     i_oversize_msg,
  output logic                          o_irq
);

  llirq_pkg::llirq_apb_req_t req;
  logic [7:0]  oversize_en_q;
  logic [7:0]  loop_en_q;
  logic        oversize_flag_q;
  logic [31:0] rdata_q;
  logic        act_lvl;
  logic        deact_lvl;
  logic        act_flag;
  logic        deact_flag;
  logic        access;
  logic        wr_en;
  logic        rd_en;
  logic        mapped;
  logic        rd_loop;
  logic        rd_over;
  logic [7:0]  rd_byte;

  assign req.psel    = i_psel;
  assign req.penable = i_penable;
  assign req.pwrite  = i_pwrite;
  assign req.paddr   = i_paddr;
  assign req.pwdata  = i_pwdata;

  // Zero-wait slave: every access completes in its first access cycle.
  assign access = req.psel && req.penable;
  assign wr_en  = access && req.pwrite;
  assign rd_en  = access && !req.pwrite;
  assign mapped = (req.paddr == llirq_pkg::OFS_OVERSIZE_EN)
               || (req.paddr == llirq_pkg::OFS_OVERSIZE_STAT)
               || (req.paddr == llirq_pkg::OFS_LOOP_STAT)
               || (req.paddr == llirq_pkg::OFS_LOOP_EN);
  assign rd_loop = rd_en && (req.paddr == llirq_pkg::OFS_LOOP_STAT);
  assign rd_over = rd_en && (req.paddr == llirq_pkg::OFS_OVERSIZE_STAT);
  assign o_pready  = 1'b1;
  assign o_pslverr = access && !mapped;

  // Enable registers; only byte lane 0 carries bits, others ignored.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      oversize_en_q <= llirq_pkg::RST_REG8;
    end else if (wr_en && i_pstrb[0] && req.paddr == llirq_pkg::OFS_OVERSIZE_EN) begin
      oversize_en_q <= {7'h00, req.pwdata[llirq_pkg::BIT_OVERSIZE_EN]};
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      loop_en_q <= llirq_pkg::RST_REG8;
    end else if (wr_en && i_pstrb[0] && req.paddr == llirq_pkg::OFS_LOOP_EN) begin
      loop_en_q <= {6'h00, req.pwdata[1:0]};
    end
  end

  // Live detection is only meaningful while its detector is enabled.
  llirq_edge_flag u_act (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_level   (i_det.act_det && i_det.act_det_en),
    .i_clr     (rd_loop && rdata_q[llirq_pkg::BIT_ACT_CHANGE]),
    .o_level   (act_lvl),
    .o_flag    (act_flag)
  );

  llirq_edge_flag u_deact (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_level   (i_det.deact_det && i_det.deact_det_en),
    .i_clr     (rd_loop && rdata_q[llirq_pkg::BIT_DEACT_CHANGE]),
    .o_level   (deact_lvl),
    .o_flag    (deact_flag)
  );

  // The LAPD receiver pulses i_oversize_msg once per message over the byte limit.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      oversize_flag_q <= 1'b0;
    end else if (i_oversize_msg) begin
      oversize_flag_q <= 1'b1;
    end else if (rd_over && rdata_q[llirq_pkg::BIT_OVERSIZE_FLAG]) begin
      oversize_flag_q <= 1'b0;
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    unique case (req.paddr)
      llirq_pkg::OFS_OVERSIZE_EN:   rd_byte = oversize_en_q;
      llirq_pkg::OFS_OVERSIZE_STAT: rd_byte = {7'h00, oversize_flag_q};
      llirq_pkg::OFS_LOOP_STAT:     rd_byte = {4'h0, act_lvl, deact_lvl, act_flag, deact_flag};
      llirq_pkg::OFS_LOOP_EN:       rd_byte = loop_en_q;
      default:                      rd_byte = 8'h00;
    endcase
  end

  // Read data is registered in the setup cycle so it stands in the access cycle.
  // A clearing read drops only the flags that the captured word showed, so an event
  // that lands after the capture survives to the next read.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (req.psel && !req.penable && !req.pwrite) begin
      rdata_q <= {24'h00_0000, rd_byte};
    end
  end

  assign o_prdata = rdata_q;

  // Interrupt request is a level built from the sticky flags and their enables.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= (oversize_flag_q && oversize_en_q[llirq_pkg::BIT_OVERSIZE_EN])
            || (act_flag && loop_en_q[llirq_pkg::BIT_ACT_EN])
            || (deact_flag && loop_en_q[llirq_pkg::BIT_DEACT_EN]);
    end
  end

endmodule // llirq_top

// File: bench/llirq_chk.sv
// Port checker for the loopback-code and oversize-message status block.
`timescale 1ns/100ps
module llirq_chk (
  input wire logic                  i_clk_sys,
  input wire logic                  i_rst,
  input wire logic                  i_psel,
  input wire logic                  i_penable,
  input wire logic [7:0]            i_paddr,
  input wire llirq_pkg::llirq_det_t i_det,
  input wire logic [31:0]           o_prdata,
  input wire logic                  o_pready,
  input wire logic                  o_pslverr,
  input wire logic                  o_irq
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // Only the four register words are decoded.
  wire acc = i_psel & i_penable;
  wire hit = i_paddr inside {llirq_pkg::OFS_OVERSIZE_STAT, llirq_pkg::OFS_OVERSIZE_EN,
    llirq_pkg::OFS_LOOP_STAT, llirq_pkg::OFS_LOOP_EN};
  a_ready_high: assert property (o_pready) else $error("pready low");
  a_err_unmapped: assert property (acc && !hit |-> o_pslverr) else $error("no slave error");
  a_err_mapped: assert property (acc && hit |-> !o_pslverr) else $error("false slave error");
  a_err_idle: assert property (!acc |-> !o_pslverr) else $error("slave error outside access");
  a_upper_zero: assert property (o_prdata[31:4] == 28'h000_0000) else $error("upper bits set");
  a_act_live: assert property (acc && i_paddr == llirq_pkg::OFS_LOOP_STAT |->
    o_prdata[3] == $past(i_det.act_det & i_det.act_det_en, 2)) else $error("act live wrong");
  a_deact_live: assert property (acc && i_paddr == llirq_pkg::OFS_LOOP_STAT |->
    o_prdata[2] == $past(i_det.deact_det & i_det.deact_det_en, 2)) else $error("deact live wrong");
  a_irq_reset: assert property ($past(i_rst) |-> !o_irq) else $error("irq after reset");
endmodule // llirq_chk

// File: bench/tb_top.sv
// Self-checking bench for the loopback-code and oversize-message status block.
`timescale 1ns/100ps
module tb_top;
  logic                  i_clk_sys = 0, i_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic                  ovs = 0;
  logic [7:0]            i_paddr = 0;
  logic [31:0]           i_pwdata = 0, rd, seed = 32'h0000_2E81;
  llirq_pkg::llirq_det_t i_det = '0;
  wire  [31:0]           o_prdata;
  wire                   o_pready, o_pslverr, o_irq;
  int                    n_mismatch = 0, check_count = 0;
  logic [1:0]            en, lv, pl;
  logic [3:0]            strb = 4'hF;
  localparam logic [7:0] A_OS = llirq_pkg::OFS_OVERSIZE_STAT, A_OE = llirq_pkg::OFS_OVERSIZE_EN;
  localparam logic [7:0] A_LS = llirq_pkg::OFS_LOOP_STAT, A_LE = llirq_pkg::OFS_LOOP_EN;
  always #4 i_clk_sys = ~i_clk_sys;
  llirq_top i_dut (.i_clk_sys, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .i_pstrb(strb), .o_prdata, .o_pready, .o_pslverr, .i_det, .i_oversize_msg(ovs), .o_irq);
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    i_psel <= 1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk_sys);
    i_penable <= 1;
    @(posedge i_clk_sys);
    while (o_pready !== 1'b1) @(posedge i_clk_sys);
    rd = o_prdata;
    chk(o_pslverr, !(a inside {A_OS, A_OE, A_LS, A_LE}), "pslverr");
    i_psel <= 0;
    i_penable <= 0;
    @(posedge i_clk_sys);
  endtask
  task automatic rdx(input logic [7:0] a, input logic [31:0] exp);
    apb(0, a, 0);
    chk(rd, exp, "prdata");
  endtask
  task automatic pulse_wait();
    ovs <= 1;
    @(posedge i_clk_sys);
    ovs <= 0;
    repeat (4) @(posedge i_clk_sys);
  endtask
  task automatic close_out();
    $display("Checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    // A hung handshake must still end the run with a verdict.
    #50us;
    n_mismatch++;
    close_out();
  end
  initial begin
    repeat (12) @(posedge i_clk_sys);
    i_rst <= 0;
    @(posedge i_clk_sys);
    for (int a = 8'h60; a < 8'h74; a += 4) rdx(8'(a), 0);
    apb(1, A_OE, 32'hFFFF_FFFF);
    rdx(A_OE, 1);
    strb <= 4'hE;
    apb(1, A_OE, 0);
    strb <= 4'hF;
    rdx(A_OE, 1);
    apb(1, A_OS, 32'hFFFF_FFFF);
    rdx(A_OS, 0);
    pulse_wait();
    chk(o_irq, 1, "irq");
    rdx(A_OS, 1);
    rdx(A_OS, 0);
    repeat (2) @(posedge i_clk_sys);
    chk(o_irq, 0, "irq");
    apb(1, A_OE, 0);
    pulse_wait();
    chk(o_irq, 0, "irq");
    rdx(A_OS, 1);
    // An event at the capture edge or at the clearing edge must survive to the next read.
    for (int d = 0; d < 2; d++) begin
      if (d == 1) pulse_wait();
      fork
        rdx(A_OS, 32'(d));
        begin
          repeat (d) @(posedge i_clk_sys);
          ovs <= 1;
          @(posedge i_clk_sys);
          ovs <= 0;
        end
      join
      rdx(A_OS, 1);
    end
    pl = 0;
    repeat (40) begin
      en = 2'(xs());
      apb(1, A_LE, 32'(en));
      rdx(A_LE, 32'(en));
      i_det <= 4'(xs());
      repeat (5) @(posedge i_clk_sys);
      lv = {i_det.act_det & i_det.act_det_en, i_det.deact_det & i_det.deact_det_en};
      chk(o_irq, |(en & (lv ^ pl)), "irq");
      rdx(A_LS, 32'({lv, lv ^ pl}));
      pl = lv;
    end
    close_out();
  end
endmodule // tb_top
bind llirq_top llirq_chk i_chk (.i_clk_sys, .i_rst, .i_psel, .i_penable, .i_paddr, .i_det,
  .o_prdata, .o_pready, .o_pslverr, .o_irq);
